// [shared/apcl_cfg.svh]
// Register offsets, field positions, reset values and timing counts of the audio port.
// Assumes a Wishbone slave with word-aligned registers; included by bare name.
`ifndef APCL_CFG_SVH
`define APCL_CFG_SVH

// ****************************************
// Register indices (byte address divided by four)
// ****************************************
`define APCL_IDX_CTRL0      8'h18
`define APCL_IDX_CTRL1      8'h19
`define APCL_IDX_BDIV       8'h1a
`define APCL_IDX_FCTRL      8'h1b
`define APCL_IDX_STAT       8'h1c

// ****************************************
// Field positions
// ****************************************
`define APCL_RX_LAW_BIT     0
`define APCL_RX_CMP_BIT     1
`define APCL_TX_LAW_BIT     2
`define APCL_TX_CMP_BIT     3
`define APCL_LOOP_BIT       8
`define APCL_SIDE_BIT       9
`define APCL_BDIR_BIT       6
`define APCL_FDIR_BIT       11

// ****************************************
// Reset values and programming limits
// ****************************************
`define APCL_CTRL0_RST      16'h0050
`define APCL_CTRL1_RST      16'h000a
`define APCL_BDIV_RST       5'h04
`define APCL_FRATE_RST      11'h040
`define APCL_FRATE_MIN      11'h008
`define APCL_BDIV_MAX       5'h14

`endif

// [shared/apcl_pkg.sv]
// Types shared by the audio port logic.
// Assumes apcl_cfg.svh supplies the numeric constants.
package apcl_pkg;

    // ****************************************
    // Frame machine states
    // ****************************************
    typedef enum logic [1:0] {
        APCL_IDLE,
        APCL_RUN
    } apcl_state_t;

    // ****************************************
    // Whole module state
    // ****************************************
    typedef struct packed {
        logic [15:0]  ctrl0;
        logic [15:0]  ctrl1;
        logic [4:0]   bdiv;
        logic [11:0]  fctrl;
        logic         ack;
        logic [31:0]  rdat;
        logic [1:0]   bclk_s;
        logic [1:0]   fclk_s;
        logic [1:0]   rxd_s;
        logic         bclk_in_d;
        logic         fclk_in_d;
        logic [6:0]   hcnt;
        logic         bclk;
        logic [10:0]  fcnt;
        logic         fclk;
        apcl_state_t  state;
        logic [4:0]   bitn;
        logic [15:0]  txsh;
        logic [15:0]  rxsh;
        logic [15:0]  dac;
        logic         dac_vld;
        logic         txd;
        logic         bclk_oe;
        logic         fclk_oe;
    } apcl_state_s_t;

endpackage

// [verilog/apcl_port.sv]
// Serial audio port: clock direction, clock dividers, G.711 compander and loopback.
// Assumes a classic Wishbone master on clk_i and pins that arrive asynchronous to it.
`timescale 1ns/100ps
`include "apcl_cfg.svh"

// How it works
// RL1: Master clocks run only with a path enabled
// RL2: Slave mode keeps clock drivers off
// RL3: Port control one bit 6 drives bit clock
// RL4: Frame control bit 11 drives frame clock
// RL5: Both clock directions set independently
// RL6: Five-bit code picks the bit-clock divisor
// RL7: Frame clock is bit clock over rate
// RL8: Bits 3 and 2 compand transmit data
// RL9: Bits 1 and 0 expand receive data
// RL10: Segment approximation of mu-law and A-law
// RL11: Invert all bits mu, even bits A
// RL12: Code sits in the top eight bits
// RL13: Thirteen or twelve linear bits to eight
// RL14: Sign, exponent, mantissa in code
// RL15: Any compand enable forces 8-bit words
// RL16: Frames may be eight bit clocks long
// RL17: Law bit alone gives plain 8-bit mode
// RL18: Loopback feeds microphone data to DAC
// RL19: Sidetone adds microphone data to DAC
// RL20: Mode B MSB on first edge, A second
// RL21: Frame divider uses internal or external bit clock
// RL22: External party drives input clocks continuously
// RL23: Software programs dividers in range, idle
module apcl_port (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [9:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Path enables and data
    input  wire logic        mic_enable_i,
    input  wire logic        dac_enable_i,
    input  wire logic [15:0] mic_data_i,
    output logic      [15:0] dac_data_o,
    output logic             dac_valid_o,
    // Serial pins
    input  wire logic        bclk_i,
    output logic             bclk_o,
    output logic             bclk_oe_o,
    input  wire logic        fclk_i,
    output logic             fclk_o,
    output logic             fclk_oe_o,
    input  wire logic        serial_receive_data_i,
    output logic             serial_transmit_data_o
);

    // ****************************************
    // Helper functions
    // ****************************************

    // Divisor code to bit-clock period in system clocks, doubled (x2 covers 1.5, 5.5)
    function automatic logic [6:0] apcl_div2(input logic [4:0] code);
        logic [6:0] t;
        t = 7'h08;
        case (code)
            5'h00: t = 7'h02;
            5'h01: t = 7'h03;
            5'h02: t = 7'h04;
            5'h03: t = 7'h06;
            5'h04: t = 7'h08;
            5'h05: t = 7'h0a;
            5'h06: t = 7'h0b;
            5'h07: t = 7'h0c;
            5'h08: t = 7'h10;
            5'h09: t = 7'h14;
            5'h0a: t = 7'h16;
            5'h0b: t = 7'h18;
            5'h0c: t = 7'h20;
            5'h0d: t = 7'h28;
            5'h0e: t = 7'h2c;
            5'h0f: t = 7'h30;
            5'h10: t = 7'h32;
            5'h11: t = 7'h3c;
            5'h12: t = 7'h40;
            5'h13: t = 7'h58;
            5'h14: t = 7'h60;
            default: t = 7'h08;
        endcase
        return t;
    endfunction

    // Linear 16-bit to G.711 code; law 1 is A-law
    function automatic logic [7:0] apcl_comp(input logic [15:0] x, input logic law);
        logic [7:0]  c;
        logic [12:0] m;
        logic [2:0]  e;
        logic        s;
        c = 8'h00;
        s = x[15];
        // Magnitude below the sign bit, ones complement for negatives
        m = s ? ~x[14:2] : x[14:2];                     // [RL13] 13-bit magnitude
        if (!law) begin
            // Clip before the bias so the sum stays inside 13 bits
            m = (m > 13'h1fde) ? 13'h1fff : m + 13'h0021; // Mu bias
        end else begin
            m = {1'b0, m[12:1]};                        // [RL13] 12-bit for A-law
        end
        // Segment from the highest set bit; mu segments start one bit higher
        e = 3'h0;
        for (int i = 7; i >= 1; i--) begin
            if (e == 3'h0 && (law ? m[i + 4] : m[i + 5])) begin
                e = 3'(i);
            end
        end
        if (!law) begin
            c = {s, e, m[e + 4'h1 +: 4]};               // [RL10] [RL14]
            c = ~c;                                     // [RL11]
        end else begin
            c = {~s, e, (e == 3'h0) ? m[4:1] : m[e +: 4]}; // [RL10] [RL14]
            c = c ^ 8'h55;                              // [RL11]
        end
        return c;
    endfunction

    // G.711 code back to linear 16-bit
    function automatic logic [15:0] apcl_exp(input logic [7:0] cin, input logic law);
        logic [7:0]  c;
        logic [15:0] v;
        logic [15:0] r;
        c = law ? (cin ^ 8'h55) : ~cin;                 // [RL11]
        if (!law) begin
            v = (({12'h000, c[3:0]} << 3) + 16'h0084) << c[6:4];
            v = v - 16'h0084;                           // [RL10]
            r = c[7] ? 16'(-v) : v;
        end else begin
            // Mid-step reconstruction: half a step added in every segment
            v = {8'h00, c[3:0], 4'h8};
            if (c[6:4] != 3'h0) begin
                v = ({8'h00, c[3:0], 4'h0} + 16'h0108) << (c[6:4] - 3'h1); // [RL10]
            end
            r = c[7] ? v : 16'(-v);
        end
        return r;
    endfunction

    // ****************************************
    // State
    // ****************************************
    apcl_pkg::apcl_state_s_t s_q;
    apcl_pkg::apcl_state_s_t s_d;

    logic        wb_req;
    logic [7:0]  wb_idx;
    logic        bclk_src;
    logic        fclk_src;
    logic        brise;
    logic        bfall;
    logic        frise;
    logic        run;
    logic        eight;
    logic        loop_on;
    logic [15:0] rx_lin;
    logic [15:0] tx_word;
    logic [15:0] mix;

    // Decode and derived controls
    assign wb_req  = wb_cyc_i & wb_stb_i & ~s_q.ack;
    assign wb_idx  = wb_adr_i[9:2];
    assign run     = mic_enable_i | dac_enable_i;                       // [RL1]
    // Any compand enable or law bit selects 8-bit words
    assign eight   = |s_q.ctrl0[`APCL_TX_CMP_BIT:`APCL_RX_LAW_BIT];     // [RL15] [RL17]
    assign loop_on = s_q.ctrl0[`APCL_LOOP_BIT];
    // Bit clock source: own divider when driven, else synchronised pin
    assign bclk_src = s_q.bclk_oe ? s_q.bclk : s_q.bclk_s[1];           // [RL21]
    assign fclk_src = s_q.fclk_oe ? s_q.fclk : s_q.fclk_s[1];
    assign brise    = bclk_src & ~s_q.bclk_in_d;
    assign bfall    = ~bclk_src & s_q.bclk_in_d;
    assign frise    = fclk_src & ~s_q.fclk_in_d;

    // Transmit word, received word and mixer input
    always_comb begin
        tx_word = mic_data_i;
        if (s_q.ctrl0[`APCL_TX_CMP_BIT]) begin
            tx_word = {apcl_comp(mic_data_i, s_q.ctrl0[`APCL_TX_LAW_BIT]), 8'h00}; // [RL8] [RL12]
        end else if (eight) begin
            tx_word = {mic_data_i[15:8], 8'h00};                               // [RL17]
        end
        rx_lin = s_q.rxsh;
        if (s_q.ctrl0[`APCL_RX_CMP_BIT]) begin
            rx_lin = apcl_exp(s_q.rxsh[7:0], s_q.ctrl0[`APCL_RX_LAW_BIT]);   // [RL9]
        end else if (eight) begin
            rx_lin = {s_q.rxsh[7:0], 8'h00};
        end
        mix = loop_on ? mic_data_i : rx_lin;                                  // [RL18]
        if (s_q.ctrl0[`APCL_SIDE_BIT]) begin
            mix = mix + mic_data_i;                                           // [RL19]
        end
    end

    // Next-state logic
    always_comb begin
        s_d = s_q;
        s_d.ack = 1'b0;
        // Register bus
        if (wb_req) begin
            s_d.ack = 1'b1;
            s_d.rdat = 32'h00000000;
            case (wb_idx)
                `APCL_IDX_CTRL0: s_d.rdat = {16'h0000, s_q.ctrl0};
                `APCL_IDX_CTRL1: s_d.rdat = {16'h0000, s_q.ctrl1};
                `APCL_IDX_BDIV:  s_d.rdat = {27'h0, s_q.bdiv};
                `APCL_IDX_FCTRL: s_d.rdat = {20'h00000, s_q.fctrl};
                `APCL_IDX_STAT:  s_d.rdat = {29'h0, eight, s_q.fclk_oe, s_q.bclk_oe};
                default:         s_d.rdat = 32'h00000000;
            endcase
            if (wb_we_i) begin
                case (wb_idx)
                    `APCL_IDX_CTRL0: begin
                        if (wb_sel_i[0]) s_d.ctrl0[7:0]  = wb_dat_i[7:0];
                        if (wb_sel_i[1]) s_d.ctrl0[15:8] = wb_dat_i[15:8];
                    end
                    `APCL_IDX_CTRL1: begin
                        if (wb_sel_i[0]) s_d.ctrl1[7:0]  = wb_dat_i[7:0];        // [RL3] [RL5]
                        if (wb_sel_i[1]) s_d.ctrl1[15:8] = wb_dat_i[15:8];
                    end
                    `APCL_IDX_BDIV: begin
                        if (wb_sel_i[0] && wb_dat_i[4:0] <= `APCL_BDIV_MAX) begin
                            s_d.bdiv = wb_dat_i[4:0];                           // [RL6] [RL23]
                        end
                    end
                    `APCL_IDX_FCTRL: begin
                        if (wb_sel_i[1]) s_d.fctrl[11] = wb_dat_i[11];          // [RL4] [RL5]
                        if (wb_sel_i[0] && wb_sel_i[1] && wb_dat_i[10:0] >= `APCL_FRATE_MIN) begin
                            s_d.fctrl[10:0] = wb_dat_i[10:0];                   // [RL7] [RL23]
                        end
                    end
                    default: ;
                endcase
            end
        end
        // Pin synchronisers
        s_d.bclk_s = {s_q.bclk_s[0], bclk_i};
        s_d.fclk_s = {s_q.fclk_s[0], fclk_i};
        s_d.rxd_s  = {s_q.rxd_s[0], serial_receive_data_i};
        s_d.bclk_in_d = bclk_src;
        s_d.fclk_in_d = fclk_src;
        // Drivers on only when direction is output and a path runs
        s_d.bclk_oe = s_q.ctrl1[`APCL_BDIR_BIT] & run;                          // [RL1] [RL2] [RL3]
        s_d.fclk_oe = s_q.fctrl[`APCL_FDIR_BIT] & run;                          // [RL1] [RL2] [RL4]
        // Bit clock divider, toggles at half period (fractional codes round up to 2 and 6)
        if (!run) begin
            s_d.hcnt = 7'h00;
            s_d.bclk = 1'b0;
        // Low half lasts floor(div/2), high half ceil(div/2) system clocks, for whole divisors from 2
        end else if ({1'b0, s_q.hcnt, 2'b00} + (s_q.bclk ? 10'h004 : 10'h006)
                     >= {3'h0, apcl_div2(s_q.bdiv)}) begin
            s_d.hcnt = 7'h00;                                                   // [RL6]
            s_d.bclk = ~s_q.bclk;
        end else begin
            s_d.hcnt = s_q.hcnt + 7'h01;
        end
        // Frame clock divider, one bit clock high pulse per frame
        if (!run) begin
            s_d.fcnt = 11'h000;
            s_d.fclk = 1'b0;
        end else if (brise) begin
            s_d.fclk = (s_q.fcnt == 11'h000);                                   // [RL7] [RL16]
            s_d.fcnt = (s_q.fcnt + 11'h001 >= s_q.fctrl[10:0]) ? 11'h000 : s_q.fcnt + 11'h001;
        end
        // Serial shifter
        s_d.dac_vld = 1'b0;
        case (s_q.state)
            apcl_pkg::APCL_IDLE: begin
                if (frise) begin
                    s_d.state = apcl_pkg::APCL_RUN;
                    // Mode B: MSB at first rise, mode A one rise later
                    // 5'h1e marks the rise that mode A skips
                    s_d.bitn = s_q.ctrl1[4] ? 5'h1f : 5'h1e;                    // [RL20]
                    // MSB goes out at frame start so the first rise sees it
                    s_d.txd  = tx_word[15];
                    s_d.txsh = {tx_word[14:0], 1'b0};
                end
            end
            apcl_pkg::APCL_RUN: begin
                // No shift before the MSB has been sampled
                if (bfall && s_q.bitn != 5'h1f && s_q.bitn != 5'h1e) begin
                    s_d.txd  = s_q.txsh[15];
                    s_d.txsh = {s_q.txsh[14:0], 1'b0};
                end
                if (brise) begin
                    s_d.bitn = s_q.bitn + 5'h01;
                    if (s_q.bitn != 5'h1e) begin
                        s_d.rxsh = {s_q.rxsh[14:0], s_q.rxd_s[1]};
                    end
                    // Samples at 5'h1f then 0 onward: 8 or 16 in all
                    if (s_q.bitn == (eight ? 5'h06 : 5'h0e)) begin              // [RL15] [RL16]
                        s_d.state = apcl_pkg::APCL_IDLE;
                    end
                end
            end
            default: s_d.state = apcl_pkg::APCL_IDLE;
        endcase
        if (s_q.state == apcl_pkg::APCL_RUN && s_d.state == apcl_pkg::APCL_IDLE) begin
            s_d.dac_vld = 1'b1;
        end
        if (s_q.dac_vld) begin
            s_d.dac = mix;                                                      // [RL18] [RL19]
        end
        if (!run) begin
            s_d.state = apcl_pkg::APCL_IDLE;
        end
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '0;
            s_q.ctrl0 <= `APCL_CTRL0_RST;
            s_q.ctrl1 <= `APCL_CTRL1_RST;
            s_q.bdiv  <= `APCL_BDIV_RST;
            s_q.fctrl <= {1'b0, `APCL_FRATE_RST};
            s_q.state <= apcl_pkg::APCL_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from flip-flops
    assign wb_dat_o  = s_q.rdat;
    assign wb_ack_o  = s_q.ack;
    assign dac_data_o  = s_q.dac;
    assign dac_valid_o = s_q.dac_vld;
    assign bclk_o    = s_q.bclk;
    assign bclk_oe_o = s_q.bclk_oe;
    assign fclk_o    = s_q.fclk;
    assign fclk_oe_o = s_q.fclk_oe;
    assign serial_transmit_data_o = s_q.txd;

endmodule // apcl_port

// [testbench/apcl_port_asserts.sv]
// Port-level checks of the audio port.
// Assumes it is bound into apcl_port.
`timescale 1ns/100ps
module apcl_port_asserts (
    // Clock, reset, bus
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [9:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // Paths and pins
    input wire logic        mic_enable_i,
    input wire logic        dac_enable_i,
    input wire logic        dac_valid_o,
    input wire logic        bclk_o,
    input wire logic        bclk_oe_o,
    input wire logic        fclk_o,
    input wire logic        fclk_oe_o
);
    // ****************
    // Checks
    // ****************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic req;
    // Request not yet answered
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    chk_ack_answer: assert property (req |=> wb_ack_o)
        else $error("bus ack missing");
    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("bus ack too long");
    chk_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
        else $error("bus ack without request");
    chk_unmapped_zero: assert property (req && !wb_we_i && wb_adr_i[9:2] > 8'h1c
        |=> wb_dat_o == 32'h00000000) else $error("unmapped read not zero");
    chk_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
        else $error("upper read bits set");
    chk_clk_still: assert property ((!mic_enable_i && !dac_enable_i) [*4]
        |-> $stable(bclk_o) && $stable(fclk_o)) else $error("clock runs idle");
    chk_valid_pulse: assert property (dac_valid_o |=> !dac_valid_o)
        else $error("dac valid too long");
    chk_reset_quiet: assert property ($fell(rst_i) |-> !bclk_oe_o && !fclk_oe_o
        && !wb_ack_o && !dac_valid_o) else $error("outputs busy after reset");
    cover property (bclk_oe_o && $rose(bclk_o));
    cover property (dac_valid_o);
    cover property (req && !wb_we_i && wb_adr_i[9:2] == 8'h1d);
endmodule // apcl_port_asserts

bind apcl_port apcl_port_asserts u_chk (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .mic_enable_i(mic_enable_i), .dac_enable_i(dac_enable_i), .dac_valid_o(dac_valid_o),
    .bclk_o(bclk_o), .bclk_oe_o(bclk_oe_o), .fclk_o(fclk_o), .fclk_oe_o(fclk_oe_o)
);

// [testbench/apcl_far.sv]
// Far-side audio port: drives bit clock, frame clock and receive data.
// Assumes 8-bit frames, mode B, sixteen system clocks a bit.
`timescale 1ns/100ps
module apcl_far (
    // Clock and control
    input  wire logic       clk_i,
    input  wire logic       run_i,
    // Serial pins
    input  wire logic [7:0] code_i,
    input  wire logic       txd_i,
    output logic            bclk_o,
    output logic            fclk_o,
    output logic            rxd_o,
    output logic [7:0]      cap_o
);
    logic [6:0] cnt_q;
    logic [6:0] nxt;
    logic [7:0] sh_q;
    assign nxt = cnt_q + 7'h01;
    // Bit phase, frame pulse, data out, capture
    always_ff @(posedge clk_i) begin
        if (!run_i) begin
            cnt_q <= 7'h00;
            bclk_o <= 1'b0;
            fclk_o <= 1'b0;
            rxd_o <= (rxd_o === 1'b0); // Released line keeps changing
        end else begin
            cnt_q <= nxt;
            bclk_o <= nxt[3];
            fclk_o <= (nxt[6:4] == 3'h0);
            rxd_o <= code_i[3'h7 - nxt[6:4]];
            if (nxt[3:0] == 4'h8) sh_q <= {sh_q[6:0], txd_i};
            if (nxt == 7'h79) cap_o <= sh_q;
        end
    end
endmodule // apcl_far

// [testbench/apcl_port_tb.sv]
// Self-checking bench of the audio port.
// Assumes apcl_far as the far side and Wishbone tasks as software.
`timescale 1ns/100ps
`include "apcl_cfg.svh"
module apcl_port_tb;
    typedef struct packed { logic [9:0] a; logic [15:0] d; logic [15:0] e; } apcl_row_t;
    logic clk_i, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, run = 1'b0;
    logic mic_en = 1'b0, dac_en = 1'b0, bclk, fclk, bp, fp, rxd, txd, dvld, boe, foe;
    logic [9:0] adr = 10'h000;
    logic [31:0] wdat = 32'h00000000, rdat;
    logic [15:0] mic = 16'h0000, dac, q;
    logic [7:0] code = 8'h00, cap;
    int n_errors = 0, check_count = 0, p, i, c;
    apcl_row_t rr [9] = '{'{10'h068, 16'h0014, 16'h0014}, '{10'h068, 16'h0015, 16'h0014},
        '{10'h06c, 16'h0007, 16'h0040}, '{10'h06c, 16'h07ff, 16'h07ff},
        '{10'h06c, 16'h0808, 16'h0808}, '{10'h064, 16'h005a, 16'h005a},
        '{10'h060, 16'h010f, 16'h010f}, '{10'h074, 16'h1234, 16'h0000},
        '{10'h068, 16'h0002, 16'h0002}};
    apcl_row_t cr [6] = '{'{10'h008, 16'h0000, 16'h00ff}, '{10'h008, 16'h7fff, 16'h0080},
        '{10'h008, 16'h8000, 16'h0000}, '{10'h00c, 16'h7fff, 16'h00aa},
        '{10'h00c, 16'h8000, 16'h002a}, '{10'h004, 16'h5a00, 16'h005a}};
    apcl_port dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .mic_enable_i(mic_en), .dac_enable_i(dac_en), .mic_data_i(mic),
        .dac_data_o(dac), .dac_valid_o(dvld), .bclk_i(bp), .bclk_o(bclk), .bclk_oe_o(boe),
        .fclk_i(fp), .fclk_o(fclk), .fclk_oe_o(foe), .serial_receive_data_i(rxd),
        .serial_transmit_data_o(txd));
    apcl_far far (.clk_i(clk_i), .run_i(run), .code_i(code), .txd_i(txd), .bclk_o(bp),
        .fclk_o(fp), .rxd_o(rxd), .cap_o(cap));
    // Verdict
    task automatic results();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Compare and count
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // One classic Wishbone cycle, entered just after an edge
    task automatic bus(input logic w, input logic [9:0] a, input logic [15:0] d);
        int k;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {16'h0000, d};
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (ack !== 1'b1 && k < 16);
        q = rdat[15:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
        if (k >= 16) begin
            n_errors++;
            results();
        end
    endtask
    // Cycles between two rises of a design clock
    task automatic per(input bit f, output int r);
        logic o, s;
        int k, e;
        o = 1'b1;
        e = 0;
        for (k = 0; k < 400 && e < 2; k++) begin
            @(posedge clk_i);
            s = f ? fclk : bclk;
            if (s === 1'b1 && o === 1'b0) begin
                e++;
                r = (e == 2) ? k - r : k;
            end
            o = s;
        end
        if (e < 2) begin
            n_errors++;
            results();
        end
    endtask
    // Next DAC word after a valid pulse
    task automatic vwait();
        int k;
        k = 0;
        while (dvld !== 1'b1 && k < 400) begin
            @(posedge clk_i);
            k++;
        end
        if (k >= 400) begin
            n_errors++;
            results();
        end
        repeat (2) @(posedge clk_i);
    endtask
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    // ****************
    // Main sequence
    // ****************
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        for (i = 0; i < 9; i++) begin
            bus(1'b1, rr[i].a, rr[i].d);
            bus(1'b0, rr[i].a, 16'h0000);
            chk(q, rr[i].e);
        end
        $display("test registers done");
        // Master clocks: still while idle, then divided
        c = 0;
        repeat (40) begin
            @(posedge clk_i);
            if (bclk !== 1'b0 || fclk !== 1'b0) c++;
        end
        chk(c[15:0], 16'h0000);
        mic_en <= 1'b1;
        per(1'b0, p);
        chk(p[15:0], 16'h0002);
        per(1'b1, p);
        chk(p[15:0], 16'h0010);
        chk({14'h0000, boe, foe}, 16'h0003);
        // Mixed: frame out from outside bit clock
        run <= 1'b1;
        bus(1'b1, 10'h064, 16'h001a);
        per(1'b1, p);
        per(1'b1, p);
        chk(p[15:0], 16'h0080);
        chk({14'h0000, boe, foe}, 16'h0001);
        $display("test clocks done");
        // Slave companding and plain 8-bit words through the far side
        bus(1'b1, 10'h06c, 16'h0040);
        dac_en <= 1'b1;
        for (i = 0; i < 6; i++) begin
            bus(1'b1, 10'h060, {6'h00, cr[i].a});
            mic <= cr[i].d;
            repeat (400) @(posedge clk_i);
            chk({8'h00, cap}, cr[i].e);
            chk({14'h0000, boe, foe}, 16'h0000);
        end
        $display("test compand done");
        code <= 8'hff;
        bus(1'b1, 10'h060, 16'h0002);
        repeat (300) @(posedge clk_i);
        vwait();
        chk(dac, 16'h0000);
        code <= 8'h00;
        mic <= 16'h0000;
        bus(1'b1, 10'h060, 16'h010a);
        repeat (300) @(posedge clk_i);
        vwait();
        chk(dac, 16'h0000);
        mic <= 16'h0123;
        bus(1'b1, 10'h060, 16'h0300);
        repeat (300) @(posedge clk_i);
        vwait();
        chk(dac, 16'h0246);
        $display("test receive done");
        // Reset values after a second reset
        rst_i <= 1'b1;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        bus(1'b0, 10'h060, 16'h0000);
        chk(q, `APCL_CTRL0_RST);
        bus(1'b0, 10'h064, 16'h0000);
        chk(q, `APCL_CTRL1_RST);
        bus(1'b0, 10'h068, 16'h0000);
        chk(q, {11'h000, `APCL_BDIV_RST});
        bus(1'b0, 10'h06c, 16'h0000);
        chk(q, {5'h00, `APCL_FRATE_RST});
        $display("test reset done");
        results();
    end
endmodule // apcl_port_tb
